// >>> design/qpc_counter.sv
`timescale 1ns/1ps
module qpc_counter
  import qpc_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              arst_n_i,
  input  wire qpc_ctrl_s [3:0]   ctrl_i,
  input  wire logic [3:0]        cnt24_i,
  input  wire logic              cnt5_i,
  input  wire logic [3:0]        gate_i,
  output qpc_stat_s              stat_o,
  output logic [3:0][15:0]       count_o,
  output logic [3:0]             dout_o,
  output logic [3:0]             gate_led_o
);

  logic [3:0][15:0] mode_q;
  logic [3:0][15:0] tgt_q;
  logic [3:0][3:0]  err_q;
  logic [3:0][15:0] cnt_q;
  logic [3:0]       done_q;
  logic [3:0]       over_q;
  logic [3:0]       run_q;
  logic [3:0]       hold_q;
  logic [3:0][TMR_W-1:0] hold_cnt_q;
  logic [3:0][TMR_W-1:0] hold_len_q;
  logic [3:0][TMR_W-1:0] cyc_cnt_q;
  logic [3:0]       gate_f;
  logic [3:0]       gate_on;
  logic [3:0]       gate_on_q;
  logic [3:0]       in24_q;
  logic             in5_q;
  logic [3:0]       pulse;
  logic [3:0]       req;
  logic [3:0]       chg_q;
  logic [3:0][3:0]  req_err;
  logic [1:0]       diff_act;
  logic [3:0][15:0] mode_nx;
  logic [3:0][15:0] tgt_nx;

  // only ch1 and ch3 can own a differential pair
  assign diff_act[0] = mode_q[0][MB_DIFF];
  assign diff_act[1] = mode_q[2][MB_DIFF];

  // the change bit is edge-detected so one scan yields one reload; a bit held high
  // gives a single request on its rising edge and does not keep the channel reset
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      chg_q     <= '0;
      in24_q    <= '0;
      in5_q     <= 1'b0;
      gate_on_q <= '0;
    end
    else
    begin
      for (int i = 0; i < NCH; i++)
      begin
        chg_q[i] <= ctrl_i[i].mode[MB_CHANGE];
      end
      in24_q    <= cnt24_i;
      in5_q     <= cnt5_i;
      gate_on_q <= gate_on;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_ch
      logic [15:0] m;
      logic [15:0] t;
      logic        rising;
      logic        falling;
      logic        sub_pair;

      assign m       = ctrl_i[g].mode;
      assign t       = ctrl_i[g].target;
      assign rising  = cnt24_i[g] & ~in24_q[g];
      assign falling = ~cnt5_i & in5_q;

      qpc_debounce u_gate (
        .clk_sys_i (clk_sys_i),
        .arst_n_i  (arst_n_i),
        .raw_i     (gate_i[g]),
        .filt_o    (gate_f[g])
      );

      assign gate_on[g]    = gate_f[g] ^ mode_q[g][MB_GATE_LVL];
      assign gate_led_o[g] = gate_f[g];
      assign req[g]        = ctrl_i[g].mode[MB_CHANGE] & ~chg_q[g];

      // mode and target in force after this edge; the reload must not see the old ones
      assign mode_nx[g] = (req[g] && req_err[g] == ERR_NONE) ? m : mode_q[g];
      assign tgt_nx[g]  = (req[g] && req_err[g] == ERR_NONE) ? t : tgt_q[g];

      // fast mode uses only the 5 V input and its falling edge
      if (g == 0)
      begin : g_fast
        assign pulse[g] = mode_q[g][MB_FAST] ? falling : rising;
      end
      else
      begin : g_slow
        assign pulse[g] = rising;
      end

      assign sub_pair = (g % 2 == 1) && diff_act[g/2];

      always_comb
      begin
        req_err[g] = ERR_NONE;
        if (sub_pair)
          req_err[g] = ERR_SLAVE_BUSY;
        else if (m[MB_DIFF] && (g % 2 == 1))
          req_err[g] = ERR_DIFF_CH;
        else if (m[MB_FAST] && g != 0)
          req_err[g] = ERR_FAST_CH;
        else if (m[MB_DIFF] && m[MB_FAST])
          req_err[g] = ERR_DIFF_FAST;
        else if (m[MB_DIFF] && m[MB_REPEAT])
          req_err[g] = ERR_DIFF_REPEAT;
        else if (!m[MB_DIFF] && t > TARGET_MAX)
          req_err[g] = ERR_TARGET;
      end

      always_ff @(posedge clk_sys_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
        begin
          mode_q[g] <= '0;
          tgt_q[g]  <= '0;
          err_q[g]  <= ERR_NONE;
        end
        else if (req[g])
        begin
          err_q[g] <= req_err[g];
          if (req_err[g] == ERR_NONE)
          begin
            mode_q[g] <= m;
            tgt_q[g]  <= t;
          end
        end
      end
    end
  endgenerate

  // count engine per channel; even channels (ch2, ch4) feed their owner when paired
  generate
    for (g = 0; g < NCH; g++)
    begin : g_cnt
      logic        diff;
      logic        slave;
      logic        up;
      logic        dn;
      logic        hit;
      logic        rep;
      logic [15:0] nxt;

      assign diff  = (g % 2 == 0) && mode_q[g][MB_DIFF];
      assign slave = (g % 2 == 1) && diff_act[g/2];
      assign rep   = mode_q[g][MB_REPEAT];

      always_comb
      begin
        up  = 1'b0;
        dn  = 1'b0;
        nxt = cnt_q[g];
        if (diff)
        begin
          up = pulse[g] & gate_on[g];
          // partner index stays in range on the last channel, where diff is never set
          dn = pulse[g | 1] & gate_on[g | 1];
          if (up && !dn && cnt_q[g] != CNT_MAX)
            nxt = cnt_q[g] + 16'h0001;
          else if (dn && !up && cnt_q[g] != CNT_MIN_SGN)
            nxt = cnt_q[g] - 16'h0001;
        end
        else if (!slave && pulse[g] && gate_on[g] && run_q[g])
        begin
          if (mode_q[g][MB_DOWN])
          begin
            if (cnt_q[g] != 16'h0000)
              nxt = cnt_q[g] - 16'h0001;
          end
          else if (cnt_q[g] != CNT_MAX)
            nxt = cnt_q[g] + 16'h0001;
        end
      end

      assign hit = !diff && !slave &&
                   (mode_q[g][MB_DOWN] ? (nxt == 16'h0000) : (nxt == tgt_q[g]));

      always_ff @(posedge clk_sys_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
        begin
          cnt_q[g]      <= '0;
          done_q[g]     <= 1'b0;
          over_q[g]     <= 1'b0;
          run_q[g]      <= 1'b0;
          hold_q[g]     <= 1'b0;
          hold_cnt_q[g] <= '0;
          hold_len_q[g] <= '0;
          cyc_cnt_q[g]  <= '0;
        end
        else if (req[g] || (gate_on[g] && !gate_on_q[g]))
        begin
          // reload on mode change or gate re-assertion restarts a count
          cnt_q[g]  <= mode_nx[g][MB_DOWN] && !mode_nx[g][MB_DIFF] ? tgt_nx[g] : 16'h0000;
          cyc_cnt_q[g] <= '0;
          done_q[g] <= 1'b0;
          over_q[g] <= 1'b0;
          run_q[g]  <= 1'b1;
          hold_q[g] <= 1'b0;
        end
        else
        begin
          if (cyc_cnt_q[g] != {TMR_W{1'b1}})
            cyc_cnt_q[g] <= cyc_cnt_q[g] + TMR_W'(1);
          if (hold_q[g])
          begin
            hold_cnt_q[g] <= hold_cnt_q[g] + TMR_W'(1);
            if (hold_cnt_q[g] >= hold_len_q[g])
            begin
              hold_q[g] <= 1'b0;
              done_q[g] <= 1'b0;
            end
          end
          if (run_q[g] && hit && nxt != cnt_q[g] && rep)
          begin
            // length taken from the cycle just finished: a quarter of it, floored
            cnt_q[g]      <= mode_q[g][MB_DOWN] ? tgt_q[g] : 16'h0000;
            done_q[g]     <= 1'b1;
            hold_q[g]     <= 1'b1;
            hold_cnt_q[g] <= '0;
            hold_len_q[g] <= ((cyc_cnt_q[g] >> 2) > TMR_W'(PULSE_MIN_CYC)) ?
                             (cyc_cnt_q[g] >> 2) : TMR_W'(PULSE_MIN_CYC);
            cyc_cnt_q[g]  <= '0;
          end
          else
          begin
            cnt_q[g] <= nxt;
            if (run_q[g] && hit && nxt != cnt_q[g])
            begin
              done_q[g] <= 1'b1;
              // fast one-time mode freezes at the target, or at 0 when counting down
              if (mode_q[g][MB_FAST])
                run_q[g] <= 1'b0;
            end
            else if (done_q[g] && !rep && nxt != cnt_q[g])
              over_q[g] <= 1'b1;
          end
        end
      end

      assign dout_o[g]  = done_q[g] ^ mode_q[g][MB_OUT_LVL];
      assign count_o[g] = cnt_q[g];
    end
  endgenerate

  always_comb
  begin
    stat_o        = '0;
    stat_o.status[ST_DONE_LSB +: NCH] = done_q;
    stat_o.status[ST_OVER_LSB +: NCH] = over_q;
    stat_o.errors = {err_q[3], err_q[2], err_q[1], err_q[0]};
  end

endmodule

// >>> design/qpc_pkg.sv
package qpc_pkg;

  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned NCH           = 4;

  // mode control word bit positions
  localparam int unsigned MB_REPEAT     = 0;
  localparam int unsigned MB_DIFF       = 1;
  localparam int unsigned MB_FAST       = 2;
  localparam int unsigned MB_GATE_LVL   = 4;
  localparam int unsigned MB_OUT_LVL    = 5;
  localparam int unsigned MB_DOWN       = 6;
  localparam int unsigned MB_CHANGE     = 8;

  localparam logic [15:0] TARGET_MAX    = 16'h7FFF;
  localparam logic [15:0] CNT_MAX       = 16'h7FFF;
  localparam logic [15:0] CNT_MIN_SGN   = 16'h8000;

  // status word fields
  localparam int unsigned ST_DONE_LSB   = 4;
  localparam int unsigned ST_OVER_LSB   = 8;

  // mode-request error codes
  localparam logic [3:0] ERR_NONE        = 4'h0;
  localparam logic [3:0] ERR_DIFF_FAST   = 4'h1;
  localparam logic [3:0] ERR_DIFF_REPEAT = 4'h2;
  localparam logic [3:0] ERR_FAST_CH     = 4'h3;
  localparam logic [3:0] ERR_SLAVE_BUSY  = 4'h4;
  localparam logic [3:0] ERR_DIFF_CH     = 4'h5;
  localparam logic [3:0] ERR_TARGET      = 4'h6;

  // timing
  localparam int unsigned PULSE_MIN_MS  = 20;
  localparam int unsigned GATE_DLY_MS   = 4;
  localparam int unsigned PULSE_MIN_CYC = (CLK_HZ / 1000) * PULSE_MIN_MS;
  localparam int unsigned GATE_DLY_CYC  = (CLK_HZ / 1000) * GATE_DLY_MS;
  localparam int unsigned TMR_W         = 24;

  typedef struct packed {
    logic [15:0] mode;
    logic [15:0] target;
  } qpc_ctrl_s;

  typedef struct packed {
    logic [15:0] status;
    logic [15:0] errors;
  } qpc_stat_s;

endpackage

// >>> design/qpc_debounce.sv
`timescale 1ns/1ps
module qpc_debounce
  import qpc_pkg::*;
#(
  parameter int unsigned DLY_CYC = GATE_DLY_CYC
)
(
  input  wire logic clk_sys_i,
  input  wire logic arst_n_i,
  input  wire logic raw_i,
  output logic      filt_o
);

  logic [TMR_W-1:0] cnt_q;

  // level is adopted only after it has differed for the full delay
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cnt_q  <= '0;
      filt_o <= 1'b0;
    end
    else if (raw_i == filt_o)
    begin
      cnt_q <= '0;
    end
    else if (cnt_q >= TMR_W'(DLY_CYC - 1))
    begin
      cnt_q  <= '0;
      filt_o <= raw_i;
    end
    else
    begin
      cnt_q <= cnt_q + TMR_W'(1);
    end
  end

endmodule

// >>> bench/qpc_field.sv
`timescale 1ns/1ps
module qpc_field
(
  input  wire logic clk_i,
  output logic [3:0] cnt24_o,
  output logic       cnt5_o,
  output logic [3:0] gate_o
);
  initial
  begin
    cnt24_o = 4'h0;
    cnt5_o  = 1'b1;
    gate_o  = 4'hF;
  end
  // much faster than a real source; keeps the run short
  task automatic pulse(input int ch, input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      cnt24_o[ch] <= 1'b1;
      repeat (4) @(posedge clk_i);
      cnt24_o[ch] <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
  endtask
  // 5 V input idles high; each pulse is a low excursion
  task automatic fall5(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      cnt5_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      cnt5_o <= 1'b1;
      repeat (4) @(posedge clk_i);
    end
  endtask
endmodule

// >>> bench/qpc_counter_chk.sv
`timescale 1ns/1ps
module qpc_counter_chk
  import qpc_pkg::*;
(
  input wire logic            clk_sys_i,
  input wire logic            arst_n_i,
  input wire qpc_ctrl_s [3:0] ctrl_i,
  input wire logic [3:0]      gate_i,
  input wire qpc_stat_s       stat_o,
  input wire logic [3:0]      gate_led_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);
  logic [3:0]  chg_d;
  logic [3:0]  chg_q;
  logic        rise_w;
  logic [19:0] hi_q;
  assign chg_d = {ctrl_i[3].mode[MB_CHANGE], ctrl_i[2].mode[MB_CHANGE],
                  ctrl_i[1].mode[MB_CHANGE], ctrl_i[0].mode[MB_CHANGE]};
  assign rise_w = |(chg_d & ~chg_q);
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      chg_q <= 4'h0;
    else
      chg_q <= chg_d;
  end
  // raw high time of gate 1, so a too-early led rise shows
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      hi_q <= 20'h0;
    else if (!gate_i[0])
      hi_q <= 20'h0;
    else if (hi_q != 20'hFFFFF)
      hi_q <= hi_q + 20'h1;
  end
  sequence s_req(n);
    chg_d[n] && !chg_q[n];
  endsequence
  a_fast_diff_ch1:
    assert property (s_req(0) ##0 ctrl_i[0].mode[2:1] == 2'b11
      |=> stat_o.errors[3:0] == ERR_DIFF_FAST) else $error("ch1 diff fast code");
  a_diff_rep_ch1:
    assert property (s_req(0) ##0 ctrl_i[0].mode[2:0] == 3'b011
      |=> stat_o.errors[3:0] == ERR_DIFF_REPEAT) else $error("ch1 diff repeat code");
  a_target_inval:
    assert property (s_req(0) ##0 ctrl_i[0].mode[2:0] == 3'b001 && ctrl_i[0].target > TARGET_MAX
      |=> stat_o.errors[3:0] == ERR_TARGET) else $error("target code");
  a_valid_clear:
    assert property (s_req(0) ##0 ctrl_i[0].mode[2:0] == 3'b001 && ctrl_i[0].target <= TARGET_MAX
      |=> stat_o.errors[3:0] == ERR_NONE) else $error("valid repeat flagged");
  a_fast_ch3:
    assert property (s_req(2) ##0 ctrl_i[2].mode[MB_FAST]
      |=> stat_o.errors[11:8] == ERR_FAST_CH) else $error("ch3 fast code");
  a_diff_ch2_err:
    assert property (s_req(1) ##0 ctrl_i[1].mode[MB_DIFF]
      |=> stat_o.errors[7:4] inside {ERR_SLAVE_BUSY, ERR_DIFF_CH}) else $error("ch2 diff code");
  a_err_cause:
    assert property ($changed(stat_o.errors) |-> $past(rise_w)) else $error("code w/o request");
  a_gate_delay:
    assert property ($rose(gate_led_o[0]) |-> hi_q >= GATE_DLY_CYC - 2) else $error("gate early");
endmodule
bind qpc_counter qpc_counter_chk chk_u (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
  .ctrl_i(ctrl_i), .gate_i(gate_i), .stat_o(stat_o), .gate_led_o(gate_led_o));

// >>> bench/qpc_counter_bench.sv
`timescale 1ns/1ps
module qpc_counter_bench;
  import qpc_pkg::*;
  logic             clk_sys_i = 1'b0;
  logic             arst_n_i  = 1'b0;
  qpc_ctrl_s [3:0]  ctrl      = '0;
  logic [3:0]       cnt24;
  logic             cnt5;
  logic [3:0]       gate;
  qpc_stat_s        stat;
  logic [3:0][15:0] count;
  logic [3:0]       dout;
  logic [3:0]       led;
  int               errors      = 0;
  int               checks_done = 0;
  int               cyc         = 0;
  initial
  begin
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  qpc_field field_u (.clk_i(clk_sys_i), .cnt24_o(cnt24), .cnt5_o(cnt5), .gate_o(gate));
  qpc_counter dut_u (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .ctrl_i(ctrl),
    .cnt24_i(cnt24), .cnt5_i(cnt5), .gate_i(gate), .stat_o(stat), .count_o(count),
    .dout_o(dout), .gate_led_o(led));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic req(input int ch, input logic [15:0] md, input logic [15:0] tg);
    @(posedge clk_sys_i);
    ctrl[ch] <= '{md | 16'h0100, tg};
    @(posedge clk_sys_i);
    ctrl[ch].mode[MB_CHANGE] <= 1'b0;
    @(posedge clk_sys_i);
    #1;
  endtask
  task automatic err_case(input int ch, input logic [15:0] md, input logic [15:0] tg,
                          input logic [3:0] e);
    req(ch, md, tg);
    chk(16'(stat.errors[ch*4 +: 4]), 16'(e));
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic run_errors();
    chk(16'(led), 16'h0);
    err_case(0, 16'h6, 16'h0, ERR_DIFF_FAST);
    err_case(0, 16'h3, 16'h0, ERR_DIFF_REPEAT);
    err_case(1, 16'h4, 16'h0, ERR_FAST_CH);
    err_case(2, 16'h4, 16'h0, ERR_FAST_CH);
    err_case(1, 16'h2, 16'h0, ERR_DIFF_CH);
    err_case(3, 16'h2, 16'h0, ERR_DIFF_CH);
    err_case(0, 16'h1, 16'h8000, ERR_TARGET);
    err_case(0, 16'h1, 16'h7FFF, ERR_NONE);
    err_case(0, 16'h2, 16'h0, ERR_NONE);
    err_case(1, 16'h0, 16'h0, ERR_SLAVE_BUSY);
    err_case(2, 16'h2, 16'h0, ERR_NONE);
    err_case(3, 16'h0, 16'h0, ERR_SLAVE_BUSY);
  endtask
  task automatic run_diff();
    chk(16'(led), 16'hF);
    req(0, 16'h42, 16'h0);
    req(2, 16'h2, 16'h0);
    field_u.pulse(0, 3);
    field_u.pulse(1, 5);
    field_u.pulse(2, 2);
    field_u.pulse(3, 1);
    #1;
    chk(count[0], 16'hFFFE);
    chk(count[2], 16'h1);
    chk(count[1], 16'h0);
    chk(count[3], 16'h0);
  endtask
  task automatic run_done();
    req(0, 16'h0, 16'h3);
    field_u.pulse(0, 3);
    #1;
    chk({stat.status[4], dout[0], count[0][13:0]}, 16'hC003);
    field_u.pulse(0, 1);
    #1;
    chk({stat.status[11:8], count[0][11:0]}, 16'h1004);
    chk(16'(dout), 16'h1);
    req(0, 16'h1, 16'h2);
    field_u.pulse(0, 3);
    #1;
    chk({stat.status[4], dout[0], count[0][13:0]}, 16'hC001);
  endtask
  task automatic run_fast();
    req(0, 16'h24, 16'h2);
    field_u.pulse(0, 2);
    #1;
    chk(count[0], 16'h0);
    field_u.fall5(3);
    #1;
    chk({stat.status[4], dout[0], count[0][13:0]}, 16'h8002);
  endtask
  initial
  begin
    repeat (2) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    run_errors();
    while (led !== 4'hF && cyc < 100100) @(posedge clk_sys_i);
    #1;
    run_diff();
    run_done();
    run_fast();
    summarize();
  end
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 110000)
    begin
      errors++;
      $display("MISMATCH t=%0t timeout", $time);
      summarize();
    end
  end
endmodule
